// [bench/radio_ctrl_asserts.sv]
// checker: port-level assertions for the radio command controller
`timescale 1ns/10ps
module radio_ctrl_asserts
    import radio_ctrl_pkg::*;
#(
    parameter int CALIB_CYC = 16
) (
    input wire logic        pclk,       // clock
    input wire logic        presetn,    // reset, active low
    input wire logic        wake_pin,   // wake level
    input wire logic        uart_rx_en, // reception open
    input wire logic        uart_on,    // uart power
    input wire logic        radio_on,   // radio power
    input wire logic        msg_valid,  // host message strobe
    input wire host_msg_t   msg,        // host message
    input wire logic        load_done,  // payload loaded
    input wire logic        tx_start,   // send strobe
    input wire logic        tx_done,    // packet on air
    input wire logic        rx_detect,  // packet seen
    input wire rf_pkt_t     rx_pkt,     // packet attributes
    input wire logic        fifo_read,  // fifo read strobe
    input wire ctrl_state_t state       // controller state
);
    // ==========
    // calibration length
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [31:0] cal_cnt;
    logic [31:0] next_cal_cnt;
    // a stuck calibration must show as an overrun, so count it here
    always_comb next_cal_cnt = (state == ST_CALIB) ? cal_cnt + 32'h1 : 32'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cal_cnt <= 32'h0;
        else cal_cnt <= next_cal_cnt;
    end
    chk_calib_upper: assert property (cal_cnt <= CALIB_CYC)
        else $error("calibration overran");
    chk_calib_lower: assert property (state == ST_IDLE && $past(state) == ST_CALIB
        |-> $past(cal_cnt) >= CALIB_CYC - 1) else $error("calibration too short");
    chk_rx_idle_only: assert property (uart_rx_en |-> state == ST_IDLE)
        else $error("reception open outside idle");
    chk_sleep_power: assert property (state == ST_SLEEP |-> !uart_on && !radio_on)
        else $error("power on in sleep");
    chk_half_duplex: assert property (!(tx_start && fifo_read))
        else $error("send and receive together");
    chk_tx_after_load: assert property (tx_start |-> load_done || $past(load_done))
        else $error("send before load");
    chk_rx_fifo_read: assert property (rx_detect && rx_pkt.intact && state == ST_IDLE |-> fifo_read)
        else $error("fifo not read");
    chk_wake_edge: assert property (state == ST_SLEEP && $past(wake_pin) && !wake_pin
        |=> state == ST_IDLE) else $error("no wake on falling edge");
    chk_sent_after_tx: assert property (msg_valid && msg.code == MSG_SENT
        |-> tx_done || $past(tx_done)) else $error("answer before last send");
    cov_sleep: cover property (state == ST_SLEEP);
    cov_fifo: cover property (fifo_read);
    cov_sent: cover property (msg_valid && msg.code == MSG_SENT);
endmodule

bind radio_ctrl radio_ctrl_asserts #(.CALIB_CYC(CALIB_CYC)) u_chk (
    .pclk      (pclk),
    .presetn   (presetn),
    .wake_pin  (wake_pin),
    .uart_rx_en(uart_rx_en),
    .uart_on   (uart_on),
    .radio_on  (radio_on),
    .msg_valid (msg_valid),
    .msg       (msg),
    .load_done (load_done),
    .tx_start  (tx_start),
    .tx_done   (tx_done),
    .rx_detect (rx_detect),
    .rx_pkt    (rx_pkt),
    .fifo_read (fifo_read),
    .state     (state)
);

// [bench/radio_far_model.sv]
// far-side model: transceiver memory and radio answering loads and sends
`timescale 1ns/10ps
module radio_far_model (
    input  wire logic pclk,       // clock
    input  wire logic presetn,    // reset, active low
    input  wire logic slow,       // stretch answers
    input  wire logic load_start, // load request
    input  wire logic tx_start,   // send request
    output logic      load_done,  // payload in memory
    output logic      tx_done     // packet on air
);
    // ==========
    // answer counters
    logic [3:0] ld_cnt, tx_cnt, next_ld_cnt, next_tx_cnt;
    // count down from each request, done pulses when one is reached
    always_comb begin
        next_ld_cnt = load_start ? (slow ? 4'h6 : 4'h1) : (ld_cnt != 4'h0 ? ld_cnt - 4'h1 : 4'h0);
        next_tx_cnt = tx_start ? (slow ? 4'h6 : 4'h1) : (tx_cnt != 4'h0 ? tx_cnt - 4'h1 : 4'h0);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ld_cnt <= 4'h0;
            tx_cnt <= 4'h0;
        end else begin
            ld_cnt <= next_ld_cnt;
            tx_cnt <= next_tx_cnt;
        end
    end
    assign load_done = (ld_cnt == 4'h1);
    assign tx_done   = (tx_cnt == 4'h1);
endmodule

// [bench/test_radio_ctrl.sv]
// testbench: apb, send, receive, sleep and restart checks
`timescale 1ns/10ps
module test_radio_ctrl
    import radio_ctrl_pkg::*;
;
    // ==========
    // signals
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
    logic restart_n = 1, wake_pin = 1, cmd_valid = 0, rx_detect = 0, rx_lost = 0;
    logic [7:0] paddr = 0, cmd_len = 0, tx_len;
    logic [31:0] pwdata = 0, prdata;
    logic [1:0] cmd_code = 0;
    logic pready, pslverr, uart_rx_en, uart_on, radio_on, msg_valid;
    logic load_start, load_done, tx_start, tx_done, fifo_read;
    host_msg_t msg;
    rf_pkt_t rx_pkt = '0;
    ctrl_state_t state;
    int mismatches = 0, tests_run = 0, n_tx = 0, tx_sum = 0, last_len = 0;
    int n_msg[4] = '{0, 0, 0, 0};
    always #12.5 pclk = ~pclk;
    radio_ctrl #(
        .RESTART_HOLD(8),
        .CALIB_CYC   (16)
    ) dut (
        .pclk      (pclk),
        .presetn   (presetn),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .prdata    (prdata),
        .pready    (pready),
        .pslverr   (pslverr),
        .restart_n (restart_n),
        .wake_pin  (wake_pin),
        .cmd_valid (cmd_valid),
        .cmd_code  (cmd_code),
        .cmd_len   (cmd_len),
        .uart_rx_en(uart_rx_en),
        .uart_on   (uart_on),
        .radio_on  (radio_on),
        .msg_valid (msg_valid),
        .msg       (msg),
        .load_start(load_start),
        .load_done (load_done),
        .tx_start  (tx_start),
        .tx_len    (tx_len),
        .tx_done   (tx_done),
        .rx_detect (rx_detect),
        .rx_pkt    (rx_pkt),
        .rx_lost   (rx_lost),
        .fifo_read (fifo_read),
        .state     (state)
    );
    radio_far_model far (
        .pclk      (pclk),
        .presetn   (presetn),
        .slow      (slow),
        .load_start(load_start),
        .tx_start  (tx_start),
        .load_done (load_done),
        .tx_done   (tx_done)
    );
    // tally host messages and sent bytes
    always @(posedge pclk) begin
        if (msg_valid === 1'b1) begin
            n_msg[msg.code]++;
            last_len = msg.len;
        end
        if (tx_start === 1'b1) begin
            n_tx++;
            tx_sum += tx_len;
        end
    end
    task automatic chk(input string name, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic cmd(input logic [1:0] c, input logic [7:0] l);
        cmd_valid <= 1'b1;
        cmd_code  <= c;
        cmd_len   <= l;
        @(posedge pclk);
        cmd_valid <= 1'b0;
    endtask
    task automatic rx(input logic f, l, input logic [7:0] n);
        rx_detect <= 1'b1;
        rx_pkt    <= '{f, l, 1'b1, n};
        @(posedge pclk);
        rx_detect <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic wt(input int c, n);
        for (int i = 0; i < 400 && n_msg[c] < n; i++) @(posedge pclk);
    endtask
    task automatic end_sim;
        if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        logic [31:0] q;
        logic e;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // nothing on the command port before the ready message
        wt(MSG_READY, 1);
        chk("ready", n_msg[MSG_READY], 1);
        apb(1'b0, CFG_ADDR, 32'h0, q, e);
        chk("cfg reset", q, 32'h9);
        apb(1'b1, 8'h08, 32'hff, q, e);
        chk("unmapped", e, 1);
        // a plain payload of the transfer unit is sent, one byte over it is refused
        cmd(CMD_SEND, 8'd26);
        wt(MSG_SENT, 1);
        chk("tx n", n_tx, 1);
        chk("tx sum", tx_sum, 26);
        cmd(CMD_SEND, 8'd27);
        wt(MSG_SENT, 2);
        chk("over mtu", n_tx, 1);
        // fragmented send against a slow far side
        slow <= 1'b1;
        apb(1'b1, CFG_ADDR, 32'ha, q, e);
        cmd(CMD_SEND, 8'd240);
        wt(MSG_SENT, 2);
        chk("frag n", n_tx, 11);
        chk("frag sum", tx_sum, 266);
        chk("sent", n_msg[MSG_SENT], 2);
        rx(1'b1, 1'b0, 8'd26);
        rx(1'b1, 1'b1, 8'd10);
        chk("frag ind", n_msg[MSG_FRAG], 1);
        chk("rx len", last_len, 36);
        chk("rx n", n_msg[MSG_RX], 1);
        apb(1'b1, CFG_ADDR, 32'h8, q, e);
        rx(1'b1, 1'b0, 8'd26);
        chk("ind off", n_msg[MSG_FRAG], 1);
        apb(1'b1, CFG_ADDR, 32'h0, q, e);
        rx(1'b1, 1'b1, 8'd10);
        chk("frag drop", n_msg[MSG_RX], 1);
        rx(1'b0, 1'b0, 8'd5);
        chk("plain rx", last_len, 5);
        // fragment mode without indication, then a lost fragment
        apb(1'b1, CFG_ADDR, 32'h2, q, e);
        rx(1'b1, 1'b0, 8'd26);
        chk("ind needs bit", n_msg[MSG_FRAG], 1);
        rx_lost <= 1'b1;
        @(posedge pclk);
        rx_lost <= 1'b0;
        rx(1'b1, 1'b1, 8'd10);
        chk("lost drop", last_len, 10);
        chk("rx after lost", n_msg[MSG_RX], 3);
        // sleep, wake and kept settings
        cmd(CMD_SLEEP, 8'd0);
        @(posedge pclk);
        chk("uart off", uart_on, 0);
        chk("radio off", radio_on, 0);
        wake_pin <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("woke", state, ST_IDLE);
        apb(1'b0, CFG_ADDR, 32'h0, q, e);
        chk("cfg kept", q, 32'h2);
        // a short restart pulse is ignored, a held one restarts
        restart_n <= 1'b0;
        repeat (3) @(posedge pclk);
        restart_n <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("short pulse", state, ST_IDLE);
        restart_n <= 1'b0;
        repeat (10) @(posedge pclk);
        chk("restart", state, ST_RESTART);
        restart_n <= 1'b1;
        wt(MSG_READY, 2);
        chk("ready again", n_msg[MSG_READY], 2);
        end_sim;
    end
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        end_sim;
    end
endmodule

// [hw/radio_ctrl.sv]
// radio module command controller: start-up, buffered send, sleep, fragmentation
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/10ps

module radio_ctrl
    import radio_ctrl_pkg::*;
#(
    parameter int RESTART_HOLD = RESTART_HOLD_CYC,
    parameter int CALIB_CYC    = CALIB_MIN_CYC,
    parameter int FRAG_BYTES   = MTU_BYTES
) (
    input  wire logic       pclk,          // apb clock, 40 MHz
    input  wire logic       presetn,       // async reset, active low
    input  wire logic       psel,          // apb select
    input  wire logic       penable,       // apb access phase
    input  wire logic       pwrite,        // apb direction
    input  wire logic [7:0] paddr,         // apb byte address
    input  wire logic [31:0] pwdata,       // apb write data
    output logic [31:0]     prdata,        // apb read data
    output logic            pready,        // apb ready
    output logic            pslverr,       // apb error on unmapped address
    input  wire logic       restart_n,     // restart pin, active low
    input  wire logic       wake_pin,      // wake pin, falling edge wakes
    input  wire logic       cmd_valid,     // decoded host command strobe
    input  wire logic [1:0] cmd_code,      // decoded host command
    input  wire logic [7:0] cmd_len,       // payload length of send command
    output logic            uart_rx_en,    // uart reception allowed
    output logic            uart_on,       // uart powered
    output logic            radio_on,      // radio powered
    output logic            msg_valid,     // message to host, one cycle
    output host_msg_t       msg,           // message contents
    output logic            load_start,    // copy buffer into transceiver memory
    input  wire logic       load_done,     // transceiver memory holds payload
    output logic            tx_start,      // transmit one packet, one cycle
    output logic [7:0]      tx_len,        // length of packet transmitted
    input  wire logic       tx_done,       // packet on air
    input  wire logic       rx_detect,     // incoming packet seen
    input  wire rf_pkt_t    rx_pkt,        // incoming packet attributes
    input  wire logic       rx_lost,       // a fragment timed out
    output logic            fifo_read,     // read receive fifo, one cycle
    output ctrl_state_t     state          // controller state
);

    // ==========================================================
    // elaboration checks
    // the restart counter needs at least one cycle of low time to compare against
    if (RESTART_HOLD < 1) begin : g_bad_hold
        $error("radio_ctrl: restart hold must be at least one cycle");
    end
    // calibration may be shortened below the real minimum to keep runs short,
    // but never beyond the longest calibration the start-up allows
    if (CALIB_CYC < 1 || CALIB_CYC > CALIB_MAX_CYC) begin : g_bad_calib
        $error("radio_ctrl: calibration length out of range");
    end
    // a fragment wider than the transfer unit would overrun the radio packet
    if (FRAG_BYTES < 1 || FRAG_BYTES > MTU_BYTES) begin : g_bad_frag
        $error("radio_ctrl: fragment size out of range");
    end

    // ==========================================================
    // state
    // cnt times both calibration and the restart hold; calibration owns it
    // while it runs, so in calibration a low restart pin is judged against the calibration count
    // rx_hold keeps the packet attributes for the cycle after detection
    ctrl_state_t state_q, next_state;
    logic [31:0] cnt, next_cnt;
    logic [7:0]  cfg, next_cfg;
    logic [7:0]  remain, next_remain;
    logic [7:0]  asm_len, next_asm_len;
    logic        wake_d, next_wake_d;
    logic        rst_d, next_rst_d;
    logic        restart_req;
    logic        frag_mode, frag_ind;
    logic [7:0]  chunk;
    rf_pkt_t     rx_hold, next_rx_hold;

    assign frag_mode = cfg[CFG_FRAG_BIT];
    assign frag_ind  = frag_mode && cfg[CFG_IND_BIT];
    assign chunk     = (remain > 8'(FRAG_BYTES)) ? 8'(FRAG_BYTES) : remain;
    // outside calibration, restart only counted from a held low level; glitches fall through
    assign restart_req = !restart_n && cnt >= 32'(RESTART_HOLD - 1);

    // ==========================================================
    // apb slave, zero wait states
    // every access completes in its first access cycle, so pready is tied high
    // and the master never sees a wait state
    logic apb_wr;
    assign apb_wr  = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && paddr != CFG_ADDR && paddr != STATUS_ADDR;

    // read mux; unmapped offsets read as zero and raise pslverr instead
    always_comb begin
        prdata = 32'h0;
        if (paddr == CFG_ADDR)
            prdata = {24'h0, cfg};
        else if (paddr == STATUS_ADDR)
            prdata = {16'h0, remain, 5'h0, state_q};
    end

    // ==========================================================
    // next-state logic
    // one command or packet is taken per idle cycle; commands win over
    // receive, and a held restart pin overrides the next state at the end
    always_comb begin
        next_state   = state_q;
        next_cnt     = cnt;
        next_remain  = remain;
        next_asm_len = asm_len;
        next_rx_hold = rx_hold;
        msg_valid    = 1'b0;
        msg          = '{code: MSG_READY, len: 8'h0};
        load_start   = 1'b0;
        tx_start     = 1'b0;
        tx_len       = chunk;
        fifo_read    = 1'b0;
        // low time on the restart pin is counted in every state but restart and calibration
        if (!restart_n && state_q != ST_RESTART)
            next_cnt = cnt + 32'h1;
        else if (restart_n && !rst_d)
            next_cnt = 32'h0;
        unique case (state_q)
            // held here while the restart pin stays low
            ST_RESTART: begin
                next_cnt = 32'h0;
                if (restart_n)
                    next_state = ST_CALIB;
            end
            ST_CALIB: begin
                next_cnt = cnt + 32'h1;
                // fixed calibration keeps start-up far below one second
                if (cnt == 32'(CALIB_CYC - 1)) begin
                    next_cnt   = 32'h0;
                    next_state = ST_IDLE;
                    msg_valid  = 1'b1;
                    msg.code   = MSG_READY;
                end
            end
            // only idle listens to the host and the air
            ST_IDLE: begin
                if (cmd_valid && cmd_code == CMD_SLEEP) begin
                    next_state = ST_SLEEP;
                end else if (cmd_valid && cmd_code == CMD_RESET) begin
                    next_state = ST_RESTART;
                end else if (cmd_valid && cmd_code == CMD_SEND) begin
                    // oversize payloads are refused without answer
                    if (cmd_len != 8'h0 && (cmd_len <= 8'(MTU_BYTES) ||
                        (frag_mode && cmd_len <= 8'(FRAG_MAX)))) begin
                        next_remain = cmd_len;
                        next_state  = ST_LOAD;
                        load_start  = 1'b1;
                    end
                end else if (rx_detect && rx_pkt.intact) begin
                    if (rx_pkt.frag && !frag_mode) begin
                        fifo_read = 1'b1;
                    end else begin
                        fifo_read    = 1'b1;
                        next_state   = ST_RX;
                        next_rx_hold = rx_pkt;
                    end
                end
            end
            // wait for the transceiver memory to hold the chunk; radio stays quiet
            ST_LOAD: begin
                if (load_done) begin
                    tx_start   = 1'b1;
                    next_state = ST_TX;
                end
            end
            // one chunk on air; remain counts the bytes still to go
            ST_TX: begin
                if (tx_done) begin
                    next_remain = remain - chunk;
                    if (remain == chunk) begin
                        next_state = ST_IDLE;
                        msg_valid  = 1'b1;
                        msg.code   = MSG_SENT;
                    end else begin
                        load_start = 1'b1;
                        next_state = ST_LOAD;
                    end
                end
            end
            ST_RX: begin
                // one packet accepted; fragments accumulate here
                next_state = ST_IDLE;
                // attributes come from rx_hold, since the input may move on
                if (!rx_hold.frag) begin
                    msg_valid = 1'b1;
                    msg       = '{code: MSG_RX, len: rx_hold.len};
                end else begin
                    next_asm_len = asm_len + rx_hold.len;
                    if (rx_hold.last) begin
                        msg_valid    = 1'b1;
                        msg          = '{code: MSG_RX, len: 8'(asm_len + rx_hold.len)};
                        next_asm_len = 8'h0;
                    end else if (frag_ind) begin
                        msg_valid = 1'b1;
                        msg       = '{code: MSG_FRAG, len: rx_hold.len};
                    end
                end
            end
            // uart and radio off; only the wake and restart pins are watched
            ST_SLEEP: begin
                if (wake_d && !wake_pin)
                    next_state = ST_IDLE;
            end
        endcase
        // a lost fragment throws away the partial packet
        // a later last fragment then carries only its own bytes
        if (rx_lost)
            next_asm_len = 8'h0;
        if (restart_req)
            next_state = ST_RESTART;
    end

    // outputs derived from state
    // the uart stays on through restart so the ready message can go out at
    // once; the radio waits until calibration has begun
    // reception opens only in idle, which also keeps the link half duplex
    assign uart_on    = state_q != ST_SLEEP;
    assign radio_on   = state_q != ST_SLEEP && state_q != ST_RESTART;
    assign uart_rx_en = state_q == ST_IDLE;
    assign state      = state_q;

    // ==========================================================
    // controller registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_RESTART;
            cnt     <= 32'h0;
            remain  <= 8'h0;
            asm_len <= 8'h0;
            rx_hold <= '0;
        end else begin
            state_q <= next_state;
            cnt     <= next_cnt;
            remain  <= next_remain;
            asm_len <= next_asm_len;
            rx_hold <= next_rx_hold;
        end
    end

    // ==========================================================
    // settings
    // only the host bus writes the flags; sleep and the restart pin leave them
    always_comb begin
        next_cfg = cfg;
        if (apb_wr && paddr == CFG_ADDR)
            next_cfg = pwdata[7:0];
    end

    // settings flops reset only with presetn, so a wake keeps them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cfg <= CFG_RESET;
        else
            cfg <= next_cfg;
    end

    // ==========================================================
    // pin samples
    // previous pin levels for edge detection; both rest high after reset so
    // an idle high pin gives no false edge when reset lifts
    always_comb begin
        next_wake_d = wake_pin;
        next_rst_d  = restart_n;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_d <= 1'b1;
            rst_d  <= 1'b1;
        end else begin
            wake_d <= next_wake_d;
            rst_d  <= next_rst_d;
        end
    end

endmodule

// [hw/radio_ctrl_pkg.sv]
// package: constants, states and carriers for the radio module command controller
package radio_ctrl_pkg;

    // ==========================================================
    // timing
    localparam int CLK_HZ              = 40_000_000;
    localparam int STARTUP_MAX_MS      = 1000;
    localparam int RESTART_HOLD_MIN_MS = 10;
    localparam int CALIB_MIN_MS        = 2;
    localparam int CALIB_MAX_MS        = 20;
    localparam int RESTART_HOLD_CYC    = (CLK_HZ / 1000) * RESTART_HOLD_MIN_MS;
    localparam int CALIB_MIN_CYC       = (CLK_HZ / 1000) * CALIB_MIN_MS;
    localparam int CALIB_MAX_CYC       = (CLK_HZ / 1000) * CALIB_MAX_MS;
    localparam int STARTUP_MAX_CYC     = (CLK_HZ / 1000) * STARTUP_MAX_MS;

    // ==========================================================
    // payload limits
    localparam int MTU_BYTES  = 26;
    localparam int FRAG_MAX   = 240;

    // ==========================================================
    // apb register map (byte addresses)
    localparam logic [7:0] CFG_ADDR    = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] CFG_RESET   = 8'h09;
    localparam int         CFG_FRAG_BIT = 1;
    localparam int         CFG_IND_BIT  = 3;

    // ==========================================================
    // command codes on the decoded host command port
    localparam logic [1:0] CMD_NONE  = 2'h0;
    localparam logic [1:0] CMD_SEND  = 2'h1;
    localparam logic [1:0] CMD_SLEEP = 2'h2;
    localparam logic [1:0] CMD_RESET = 2'h3;

    // message codes toward the host
    localparam logic [1:0] MSG_READY = 2'h0;
    localparam logic [1:0] MSG_SENT  = 2'h1;
    localparam logic [1:0] MSG_FRAG  = 2'h2;
    localparam logic [1:0] MSG_RX    = 2'h3;

    typedef enum logic [2:0] {
        ST_RESTART, ST_CALIB, ST_IDLE, ST_LOAD, ST_TX, ST_RX, ST_SLEEP
    } ctrl_state_t;

    typedef struct packed {
        logic [1:0] code;
        logic [7:0] len;
    } host_msg_t;

    typedef struct packed {
        logic       frag;    // packet is one fragment of a larger one
        logic       last;    // final fragment
        logic       intact;  // crc good
        logic [7:0] len;
    } rf_pkt_t;

endpackage
